// File: logic/vib_host_pkg.sv
// Constants shared by the vibration sensor host controller.
// Assumes a 100 MHz system clock and SPI mode 3 at the sensor pins.
package vib_host_pkg;
    // ------------------------------------------------------------
    // Clocking
    // ------------------------------------------------------------
    localparam int CLK_HZ = 100000000;
    localparam int SCLK_MAX_HZ = 14000000;
    localparam int SCLK_MIN_HZ = 12500000;
    // Half period in system cycles, rounded up so the rate stays at
    // or below the maximum: 100 MHz / 14 MHz / 2 rounds up to 4.
    localparam int SCLK_HALF = (CLK_HZ + 2 * SCLK_MAX_HZ - 1)
                               / (2 * SCLK_MAX_HZ);
    localparam logic [3:0] SCLK_HALF_CNT = 4'(SCLK_HALF - 1);
    // ------------------------------------------------------------
    // Command word layout
    // ------------------------------------------------------------
    localparam int WORD_W = 16;
    localparam int RW_POS = 15;
    localparam int ADDR_MSB = 14;
    localparam int ADDR_LSB = 8;
    localparam int DATA_MSB = 7;
    localparam logic [5:0] BIT_LAST = 6'h0F;
    // ------------------------------------------------------------
    // Global command register and escape value
    // ------------------------------------------------------------
    localparam logic [6:0] GLOBAL_COMMAND_REG_ADDR = 7'h3E;
    localparam logic [15:0] ESCAPE_CODE = 16'h00E8;
    // ------------------------------------------------------------
    // Burst layout, word indices
    // ------------------------------------------------------------
    localparam logic [6:0] BURST_WORDS = 7'h64;
    localparam logic [6:0] BURST_LAST = 7'h63;
    localparam logic [6:0] IDX_X0 = 7'h01;
    localparam logic [6:0] IDX_Y0 = 7'h21;
    localparam logic [6:0] IDX_Z0 = 7'h41;
    localparam logic [6:0] IDX_TEMP = 7'h61;
    localparam logic [6:0] IDX_STAT = 7'h62;
    localparam logic [6:0] IDX_CRC = 7'h63;
    localparam logic [7:0] HEADER_LOW = 8'hAD;
    localparam logic [15:0] SAMPLE_MID = 16'h8000;
    // ------------------------------------------------------------
    // Host command codes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CMD_WRITE = 2'b00,
        CMD_READ = 2'b01,
        CMD_BURST = 2'b10,
        CMD_ESCAPE = 2'b11
    } cmd_e;
    // Tag on each result word.
    typedef enum logic [2:0] {
        TAG_READ = 3'b000,
        TAG_HEADER = 3'b001,
        TAG_X = 3'b010,
        TAG_Y = 3'b011,
        TAG_Z = 3'b100,
        TAG_TEMP = 3'b101,
        TAG_STAT = 3'b110,
        TAG_CRC = 3'b111
    } tag_e;
    localparam int FIFO_W = 19;
    localparam int FIFO_D = 4;
endpackage

// File: logic/word_fifo.sv
// Small synchronous FIFO for result words.
// Assumes one clock; a push on full and a pop on empty are ignored.
`timescale 1ns/1ps
module word_fifo #(
    parameter int WIDTH = 19,
    parameter int DEPTH = 4
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] rd_ff;
    logic [AW:0] cnt_ff;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    // Status comes from the occupancy count, so full is honest.
    assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign out_data = mem_ff[rd_ff];

    // Storage is not reset; only the pointers need a defined value.
    always_ff @(posedge clock) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data;
        end
    end

    // Pointers wrap because DEPTH is a power of two.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            wr_ff <= push ? wr_ff + 1'b1 : wr_ff;
            rd_ff <= pop ? rd_ff + 1'b1 : rd_ff;
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // word_fifo

// File: logic/vib_host.sv
// Host-side SPI master for the triaxial vibration sensor.
// Assumes the sensor is an SPI mode 3 slave with an active-low busy pin;
// busy and the data-out pin arrive asynchronously and are synchronised.
`timescale 1ns/1ps
// Contract
// - Host writes low byte then high byte
// - Write word: flag one, address, data
// - Read takes two words, first flag zero
// - Reply next word; next request overlaps
// - Host waits while busy low, except escape
// - Ignore busy until data production begins
// - One command starts a back-to-back burst
// - Select held low through whole burst
// - Burst clock between 12.5 and 14 MHz
// - First burst after entry is discarded (host passes it on, marked by first_frame)
// - Mode 3, MSB first, 16-bit words
// - Escape written to global command register
module vib_host
    import vib_host_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire vib_host_pkg::cmd_e cmd_code,
    input wire logic [6:0] cmd_addr,
    input wire logic [15:0] cmd_data,
    output logic res_valid,
    input wire logic res_ready,
    output logic [2:0] res_tag,
    output logic [15:0] res_data,
    output logic [7:0] hdr_count,
    output logic first_frame,
    output logic burst_lost,
    output logic spi_cs_n,
    output logic spi_sclk,
    output logic spi_mosi,
    input wire logic spi_miso,
    input wire logic busy_n
);
    import vib_host_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic miso_s1_ff, miso_ff, busy_s1_ff, busy_ff, started_ff;
    // Two flops per pin; only the second is read.
    // The data-out pin is read two clocks late; a four-clock half period
    // leaves it settled well before the rising edge that samples it.
    always_ff @(posedge clock) begin
        miso_s1_ff <= spi_miso;
        miso_ff <= miso_s1_ff;
        busy_s1_ff <= busy_n;
        busy_ff <= busy_s1_ff;
    end

    // Busy only counts once it has first been seen high after reset.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            started_ff <= 1'b0;
        end else if (busy_ff) begin
            started_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // State machine
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_LOAD = 3'b001,
        ST_SHIFT = 3'b010,
        ST_GAP = 3'b011,
        ST_PUSH = 3'b100
    } state_e;
    state_e state_ff;
    logic [3:0] div_ff;
    logic [5:0] bit_ff;
    logic [15:0] tx_ff, rx_ff;
    logic [6:0] word_ff;
    logic [1:0] step_ff;
    cmd_e op_ff;
    logic [6:0] addr_ff;
    logic [15:0] data_ff;
    logic burst_seen_ff;
    logic fifo_in_ready;

    // A half-period tick from the divider; the link clock is made here.
    wire tick = (div_ff == SCLK_HALF_CNT);
    wire busy_blocks = started_ff && !busy_ff;
    wire esc_cmd = cmd_valid && (cmd_code == CMD_ESCAPE);
    // The escape code is allowed to bypass busy.
    wire can_take = (state_ff == ST_IDLE)
                    && (esc_cmd || !busy_blocks);
    // Ready is left combinational: the escape bypass depends on the code
    // offered in this very cycle, which a registered ready cannot see.
    assign cmd_ready = can_take;
    wire take = cmd_valid && can_take;

    // Byte address of the second step of a register write.
    wire [6:0] addr_hi = addr_ff | 7'h01;
    // Word for the current step of the operation.
    wire [15:0] wr_lo = {1'b1, addr_ff & 7'h7E, data_ff[7:0]};
    wire [15:0] wr_hi = {1'b1, addr_hi, data_ff[15:8]};
    wire [15:0] rd_req = {1'b0, addr_ff, 8'h00};
    wire [15:0] esc_lo = {1'b1, GLOBAL_COMMAND_REG_ADDR,
                          ESCAPE_CODE[7:0]};
    wire [15:0] esc_hi = {1'b1, GLOBAL_COMMAND_REG_ADDR | 7'h01,
                          ESCAPE_CODE[15:8]};
    wire [15:0] step_word =
        (op_ff == CMD_WRITE) ? (step_ff == 2'd0 ? wr_lo : wr_hi) :
        (op_ff == CMD_ESCAPE) ? (step_ff == 2'd0 ? esc_lo : esc_hi) :
        (op_ff == CMD_READ) ? rd_req :
        (word_ff == 7'h00 ? rd_req : 16'h0000);

    // How many words each operation needs; reads need two.
    wire [6:0] words_total =
        (op_ff == CMD_BURST) ? BURST_WORDS + 7'h01 : 7'h02;
    wire last_word = (word_ff == words_total - 7'h01);
    // The reply is captured in every word after the first of a read or a burst.
    wire has_reply = (op_ff == CMD_READ || op_ff == CMD_BURST)
                     && (word_ff != 7'h00);
    wire [6:0] bidx = word_ff - 7'h01;
    wire [2:0] btag =
        (bidx == 7'h00) ? TAG_HEADER :
        (bidx < IDX_Y0) ? TAG_X :
        (bidx < IDX_Z0) ? TAG_Y :
        (bidx < IDX_TEMP) ? TAG_Z :
        (bidx == IDX_TEMP) ? TAG_TEMP :
        (bidx == IDX_STAT) ? TAG_STAT : TAG_CRC;
    // Samples are passed on offset-removed, as two's complement.
    wire is_sample = (btag == TAG_X) || (btag == TAG_Y) || (btag == TAG_Z);
    wire [15:0] bdata = is_sample ? rx_ff ^ SAMPLE_MID : rx_ff;
    // Select stays low between burst words; other commands get a gap after every word.
    wire hold_cs = (op_ff == CMD_BURST) && !last_word;

    // ------------------------------------------------------------
    // Link clock divider
    // ------------------------------------------------------------
    // The divider rests at zero in idle, so each frame opens with three
    // clocks of select low before the first falling edge.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            div_ff <= '0;
        end else begin
            div_ff <= (tick || state_ff == ST_IDLE) ? 4'h0 : div_ff + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Word sequencer
    // ------------------------------------------------------------

    // Sequencer: one word is sixteen low-high clock pairs.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_ff <= ST_IDLE;
            bit_ff <= '0;
            word_ff <= '0;
            step_ff <= '0;
            op_ff <= CMD_WRITE;
            addr_ff <= '0;
            data_ff <= '0;
            tx_ff <= '0;
            rx_ff <= '0;
            spi_cs_n <= 1'b1;
            spi_sclk <= 1'b1;
            spi_mosi <= 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    spi_cs_n <= 1'b1;
                    spi_sclk <= 1'b1;
                    if (take) begin
                        op_ff <= cmd_code;
                        addr_ff <= cmd_addr;
                        data_ff <= cmd_data;
                        word_ff <= '0;
                        step_ff <= '0;
                        state_ff <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    tx_ff <= step_word;
                    spi_mosi <= step_word[RW_POS];
                    spi_cs_n <= 1'b0;
                    bit_ff <= '0;
                    state_ff <= ST_SHIFT;
                end
                ST_SHIFT: if (tick) begin
                    if (spi_sclk) begin
                        spi_sclk <= 1'b0;
                        if (bit_ff != 6'h00) begin
                            spi_mosi <= tx_ff[RW_POS];
                        end
                    end else begin
                        // Rising edge: both sides sample here.
                        spi_sclk <= 1'b1;
                        rx_ff <= {rx_ff[14:0], miso_ff};
                        tx_ff <= {tx_ff[14:0], 1'b0};
                        bit_ff <= bit_ff + 6'h01;
                        if (bit_ff == BIT_LAST) begin
                            state_ff <= ST_PUSH;
                        end
                    end
                end
                ST_PUSH: begin
                    // Wait here while the FIFO is full; select holds.
                    // A long stall stretches a burst, so the sink must
                    // keep up if the sensor is not to overwrite its buffer.
                    if (!has_reply || fifo_in_ready) begin
                        word_ff <= word_ff + 7'h01;
                        step_ff <= step_ff + 2'd1;
                        if (last_word) begin
                            spi_cs_n <= 1'b1;
                            state_ff <= ST_GAP;
                        end else if (hold_cs) begin
                            state_ff <= ST_LOAD;
                        end else begin
                            spi_cs_n <= 1'b1;
                            state_ff <= ST_GAP;
                        end
                    end
                end
                ST_GAP: if (tick) begin
                    // Writes and reads step again; the last word ends.
                    state_ff <= (word_ff == words_total) ? ST_IDLE : ST_LOAD;
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Result words and burst bookkeeping
    // ------------------------------------------------------------
    wire fifo_push = (state_ff == ST_PUSH) && has_reply && fifo_in_ready;
    wire [2:0] push_tag = (op_ff == CMD_BURST) ? btag : TAG_READ;
    wire [15:0] push_data = (op_ff == CMD_BURST) ? bdata : rx_ff;
    wire hdr_word = fifo_push && (op_ff == CMD_BURST)
                    && (btag == TAG_HEADER);
    // A header with the wrong low byte marks the burst as lost.
    wire hdr_bad = hdr_word && (rx_ff[7:0] != HEADER_LOW);

    // Burst flags; the first burst after reset is marked for discard.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            hdr_count <= '0;
            first_frame <= 1'b0;
            burst_seen_ff <= 1'b0;
            burst_lost <= 1'b0;
        end else begin
            if (hdr_word) begin
                hdr_count <= rx_ff[15:8];
                first_frame <= !burst_seen_ff;
                burst_seen_ff <= 1'b1;
            end
            burst_lost <= hdr_bad ? 1'b1 : (take ? 1'b0 : burst_lost);
        end
    end

    // ------------------------------------------------------------
    // Result buffer and output stage
    // ------------------------------------------------------------
    // A pop happens whenever the output register is empty or is being
    // taken, so one word can move per clock with no bubble.
    wire fifo_out_valid;
    wire [FIFO_W-1:0] fifo_out_data;
    wire fifo_pop = fifo_out_valid && (!res_valid || res_ready);

    word_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_D)
    ) u_fifo (
        .clock(clock),
        .sys_rst(sys_rst),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data({push_tag, push_data}),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // Output stage keeps the result ports driven from flops.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            res_valid <= 1'b0;
            res_tag <= '0;
            res_data <= '0;
        end else if (!res_valid || res_ready) begin
            res_valid <= fifo_out_valid;
            res_tag <= fifo_out_data[18:16];
            res_data <= fifo_out_data[15:0];
        end
    end
endmodule // vib_host

// File: test/vib_host_checker.sv
// Concurrent checks on the ports of the vibration sensor host controller.
// Assumes one clock domain and the bind statement at the foot of this file.
`timescale 1ns/1ps
module vib_host_checker (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire vib_host_pkg::cmd_e cmd_code,
    input wire logic res_valid,
    input wire logic res_ready,
    input wire logic [2:0] res_tag,
    input wire logic [15:0] res_data,
    input wire logic first_frame,
    input wire logic burst_lost,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    input wire logic busy_n
);
    import vib_host_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // ------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------
    // Link clock rises per select period; refusal only counts once the
    // busy line has been seen high, since start-up toggling is ignored.
    logic [10:0] rise_cnt_ff;
    logic sclk_q_ff;
    logic seen_ff;
    always_ff @(posedge clock) begin
        sclk_q_ff <= spi_sclk;
        seen_ff <= !sys_rst && (seen_ff || busy_n);
        if (sys_rst || spi_cs_n) begin
            rise_cnt_ff <= 11'h000;
        end else if (spi_sclk && !sclk_q_ff) begin
            rise_cnt_ff <= rise_cnt_ff + 11'h001;
        end
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    reset_idle_a: assert property (
        $fell(sys_rst) |-> spi_cs_n && spi_sclk && !res_valid
        && !first_frame && !burst_lost) else $error("bad idle after reset");
    sclk_idle_a: assert property (
        spi_cs_n |-> spi_sclk) else $error("link clock low while idle");
    half_period_a: assert property (
        $fell(spi_sclk) |-> (!spi_sclk)[*4] ##1 spi_sclk)
        else $error("link clock half period wrong");
    mosi_edge_a: assert property (
        !spi_cs_n && !$past(spi_cs_n) && $changed(spi_mosi)
        |-> $fell(spi_sclk)) else $error("data out moved off falling edge");
    word_count_a: assert property (
        $rose(spi_cs_n) |-> rise_cnt_ff[3:0] == 4'h0
        && rise_cnt_ff != 11'h000) else $error("frame not whole words");
    busy_block_a: assert property (
        (!busy_n)[*4] ##1 (seen_ff && !busy_n && cmd_code != CMD_ESCAPE)
        |-> !cmd_ready) else $error("command taken while busy");
    res_hold_a: assert property (
        res_valid && !res_ready |=> res_valid && $stable(res_data)
        && $stable(res_tag)) else $error("result dropped before taken");
    start_frame_a: assert property (
        cmd_valid && cmd_ready |-> ##2 !spi_cs_n)
        else $error("select not lowered after command");
    idle_cs_a: assert property (
        cmd_ready |-> spi_cs_n) else $error("ready while frame open");
endmodule // vib_host_checker

bind vib_host vib_host_checker vib_host_checker_i (
    .clock(clock),
    .sys_rst(sys_rst),
    .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready),
    .cmd_code(cmd_code),
    .res_valid(res_valid),
    .res_ready(res_ready),
    .res_tag(res_tag),
    .res_data(res_data),
    .first_frame(first_frame),
    .burst_lost(burst_lost),
    .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk),
    .spi_mosi(spi_mosi),
    .busy_n(busy_n)
);

// File: test/sensor_model.sv
// Behavioural model of the vibration sensor serial port.
// Assumes a mode 3 master; the bench raises make_busy to hold busy low.
`timescale 1ns/1ps
module sensor_model #(
    parameter logic [6:0] STREAM_ADDR = 7'h7C
) (
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic mosi,
    output logic miso,
    output logic busy_n,
    input wire logic make_busy
);
    import vib_host_pkg::*;
    logic [7:0] regs [0:127];
    logic [15:0] rx_sh = 16'h0000;
    logic [15:0] tx_sh = 16'h0000;
    logic [4:0] nbits = 5'h00;
    logic [6:0] left = 7'h00;
    logic [6:0] last_wr = 7'h00;
    logic [7:0] hcnt = 8'h00;
    logic first = 1'b1;
    logic esc = 1'b0;
    initial begin
        miso = 1'b1;
        foreach (regs[i]) regs[i] = 8'h00;
    end
    // Busy follows the bench until an escape ends the capture.
    assign busy_n = !(make_busy && !esc);
    always @(posedge make_busy) esc = 1'b0;
    always @(negedge cs_n) nbits = 5'h00;
    // A released line shows no stale bit; a raised select loses a burst.
    always @(posedge cs_n) begin
        miso = ~miso;
        left = 7'h00;
    end
    // Burst payload: offset-binary samples, then closing words.
    function automatic logic [15:0] stream_word(input logic [6:0] n);
        if (n >= IDX_TEMP) return 16'hA000 + {9'h000, n};
        if (first && n <= 7'h08) return 16'h0000;
        return SAMPLE_MID + {9'h000, n};
    endfunction
    // Words are taken on rising edges, sixteen bits, first bit highest.
    always @(posedge sclk) begin
        if (cs_n === 1'b0) begin
            rx_sh = {rx_sh[14:0], mosi};
            nbits = nbits + 5'h01;
            if (nbits == 5'h10) begin
                nbits = 5'h00;
                if (left != 7'h00) begin
                    tx_sh = stream_word(7'd100 - left);
                    left = left - 7'h01;
                end else if (rx_sh[15]) begin
                    regs[rx_sh[14:8]] = rx_sh[7:0];
                    last_wr = rx_sh[14:8];
                    esc = esc || (rx_sh[14:8] == GLOBAL_COMMAND_REG_ADDR
                        && rx_sh[7:0] == ESCAPE_CODE[7:0]);
                    tx_sh = 16'hA5A5;
                end else if (rx_sh[14:8] == STREAM_ADDR) begin
                    first = hcnt == 8'h00;
                    tx_sh = {hcnt, HEADER_LOW};
                    hcnt = hcnt + 8'h01;
                    left = 7'd99;
                end else begin
                    tx_sh = {regs[rx_sh[14:8] | 7'h01],
                             regs[rx_sh[14:8] & 7'h7E]};
                end
            end
        end
    end
    always @(negedge sclk) begin
        if (cs_n === 1'b0) begin
            miso = tx_sh[15];
            tx_sh = {tx_sh[14:0], 1'b0};
        end
    end
endmodule // sensor_model

// File: test/tb_top.sv
// Self-checking bench for the vibration sensor host controller.
// Assumes the sensor model on the serial pins and the bound checker.
`timescale 1ns/1ps
module tb_top;
    import vib_host_pkg::*;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic cmd_valid = 1'b0;
    cmd_e cmd_code = CMD_WRITE;
    logic [6:0] cmd_addr = 7'h00;
    logic [15:0] cmd_data = 16'h0000;
    logic res_ready = 1'b0;
    logic make_busy = 1'b0;
    logic cmd_ready, res_valid, first_frame, burst_lost;
    logic [2:0] res_tag;
    logic [15:0] res_data;
    logic [7:0] hdr_count;
    logic spi_cs_n, spi_sclk, spi_mosi, spi_miso, busy_n;
    int compares = 0;
    int miscompares = 0;
    always #5 clock = ~clock;
    vib_host vib_host_i (.clock(clock), .sys_rst(sys_rst),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_code(cmd_code),
        .cmd_addr(cmd_addr), .cmd_data(cmd_data), .res_valid(res_valid),
        .res_ready(res_ready), .res_tag(res_tag), .res_data(res_data),
        .hdr_count(hdr_count), .first_frame(first_frame),
        .burst_lost(burst_lost), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso), .busy_n(busy_n));
    sensor_model sensor_model_i (.cs_n(spi_cs_n), .sclk(spi_sclk),
        .mosi(spi_mosi), .miso(spi_miso), .busy_n(busy_n),
        .make_busy(make_busy));
    task automatic tick;
        @(posedge clock);
        #1;
    endtask
    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic results;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // A wait that runs out counts as a mismatch and ends the run.
    task automatic bound(input int n);
        if (n >= 5000) begin
            miscompares++;
            $display("wrong value wait expected done seen timeout");
            results();
        end
    endtask
    task automatic send(input cmd_e c, input logic [6:0] a,
                        input logic [15:0] d);
        int n;
        cmd_valid = 1'b1;
        cmd_code = c;
        cmd_addr = a;
        cmd_data = d;
        // Let ready settle on the new code before it is first looked at.
        #1;
        for (n = 0; n < 5000 && cmd_ready !== 1'b1; n++) tick();
        bound(n);
        tick();
        cmd_valid = 1'b0;
        tick();
    endtask
    task automatic get(input logic [2:0] tag, input logic [15:0] d,
                       input logic chk);
        int n;
        res_ready = 1'b1;
        for (n = 0; n < 5000 && res_valid !== 1'b1; n++) tick();
        bound(n);
        check("res_tag", {13'h0000, res_tag}, {13'h0000, tag});
        if (chk) check("res_data", res_data, d);
        tick();
    endtask
    // Two writes, then two reads; the write leaves low byte before high.
    task automatic t_regs;
        send(CMD_WRITE, 7'h06, 16'h2345);
        send(CMD_WRITE, 7'h10, 16'hBEEF);
        send(CMD_READ, 7'h06, 16'hFFFF);
        check("low", {8'h00, sensor_model_i.regs[6]}, 16'h0045);
        check("high", {8'h00, sensor_model_i.regs[7]}, 16'h0023);
        check("order", {9'h000, sensor_model_i.last_wr}, 16'h0011);
        get(TAG_READ, 16'h2345, 1'b1);
        send(CMD_READ, 7'h10, 16'h0000);
        get(TAG_READ, 16'hBEEF, 1'b1);
        $display("test regs done");
    endtask
    // One burst with the sink stalled first for 400 clocks; only two words arrive,
    // so the buffer does not fill. From an
    // address other than the stream the header is foreign and is lost.
    task automatic t_burst(input logic [6:0] a, input logic [7:0] cnt);
        logic [15:0] e;
        logic [2:0] t;
        logic ok;
        ok = (a == 7'h7C);
        send(CMD_BURST, a, 16'h0000);
        res_ready = 1'b0;
        repeat (400) tick();
        for (int i = 0; i < 100; i++) begin
            t = i == 0 ? TAG_HEADER : i < IDX_Y0 ? TAG_X : i < IDX_Z0 ?
                TAG_Y : i < IDX_TEMP ? TAG_Z : 3'(i - 92);
            e = i == 0 ? {cnt, HEADER_LOW} :
                i >= IDX_TEMP ? 16'hA000 + 16'(i) :
                (cnt == 8'h00 && i <= 8) ? 16'h8000 : 16'(i);
            get(t, e, ok);
        end
        check("count", {8'h00, hdr_count}, {8'h00, cnt});
        check("first", {15'h0, first_frame}, {15'h0, cnt == 8'h00});
        check("lost", {15'h0, burst_lost}, {15'h0, !ok});
        $display("test burst done");
    endtask
    // Busy blocks plain commands; the escape still gets through.
    task automatic t_busy;
        int n;
        make_busy = 1'b1;
        repeat (10) tick();
        cmd_code = CMD_WRITE;
        cmd_valid = 1'b1;
        n = 0;
        repeat (50) begin
            tick();
            n += int'(cmd_ready !== 1'b0);
        end
        check("refused", 16'(n), 16'h0000);
        cmd_valid = 1'b0;
        tick();
        send(CMD_ESCAPE, GLOBAL_COMMAND_REG_ADDR, ESCAPE_CODE);
        for (n = 0; n < 5000 && busy_n !== 1'b1; n++) tick();
        bound(n);
        check("escape", {8'h00, sensor_model_i.regs[7'h3E]}, 16'h00E8);
        make_busy = 1'b0;
        send(CMD_WRITE, 7'h20, 16'h1234);
        send(CMD_READ, 7'h20, 16'h0000);
        get(TAG_READ, 16'h1234, 1'b1);
        $display("test busy done");
    endtask
    initial begin
        repeat (20) tick();
        sys_rst = 1'b0;
        repeat (3) tick();
        t_regs();
        t_burst(7'h7C, 8'h00);
        t_burst(7'h7C, 8'h01);
        t_busy();
        t_burst(7'h20, 8'h12);
        results();
    end
endmodule // tb_top
